// ### inc/tcc_regs.vh
// register word indices, control field positions and codes
// assumes word indexing on a 32-bit avalon slave, data in low 16 bits
`ifndef TCC_REGS_VH
`define TCC_REGS_VH
// word indices
`define TCC_IDX_CTL0 4'h0
`define TCC_IDX_CTL1 4'h1
`define TCC_IDX_CTL2 4'h2
`define TCC_IDX_VAL0 4'h4
`define TCC_IDX_VAL1 4'h5
`define TCC_IDX_VAL2 4'h6
`define TCC_IDX_VEC 4'h8
`define TCC_IDX_OVF 4'h9
// control field positions
`define TCC_F_FLAG 0
`define TCC_F_OVR 1
`define TCC_F_OUTV 2
`define TCC_F_LVL 3
`define TCC_F_IE 4
`define TCC_F_MODE_LO 5
`define TCC_F_MODE_HI 7
`define TCC_F_CAPM 8
`define TCC_F_LATCH 10
`define TCC_F_SYNC 11
`define TCC_F_SEL_LO 12
`define TCC_F_SEL_HI 13
`define TCC_F_EDGE_LO 14
`define TCC_F_EDGE_HI 15
// overflow register field positions
`define TCC_F_OVF_FLAG 0
`define TCC_F_OVF_IE 1
// writable control bits, flag and overrun handled apart
`define TCC_CTL_WMASK 16'hf9f4
// reset values
`define TCC_CTL_RST 16'h0000
`define TCC_VAL_RST 16'h0000
// vector codes
`define TCC_VEC_NONE 4'h0
`define TCC_VEC_CH1 4'h2
`define TCC_VEC_CH2 4'h4
`define TCC_VEC_OVF 4'ha
// output modes
`define TCC_MODE_OUT 3'h0
`define TCC_MODE_SET 3'h1
`define TCC_MODE_TGL_RST 3'h2
`define TCC_MODE_SET_RST 3'h3
`define TCC_MODE_TGL 3'h4
`define TCC_MODE_RST 3'h5
`define TCC_MODE_TGL_SET 3'h6
`define TCC_MODE_RST_SET 3'h7
`endif

// ### core/tcc_chan.v
// one capture/compare channel with its output unit
// assumes count_value/count_tick come from the counter in the clk_sys domain
`timescale 1ns/100ps
`include "tcc_regs.vh"
module tcc_chan (
  input wire clk_sys,
  input wire rst_b,
  input wire ctl_wr,
  input wire val_wr,
  input wire [15:0] wr_data,
  input wire val_rd_done,
  input wire flag_clr,
  input wire [15:0] count_value,
  input wire count_tick,
  input wire chan0_match,
  input wire capture_in_a,
  input wire capture_in_b,
  output wire [15:0] ctl_rd,
  output reg [15:0] chan_value_reg,
  output reg chan_irq_flag,
  output wire chan_irq_enable,
  output wire chan_match,
  output reg chan_out
);
  reg [15:0] ctl; // writable control bits
  reg capture_overrun; // second capture before read
  reg lvl_prev; // input level one cycle ago
  reg cap_pend; // capture held for the next edge
  reg latched_input; // level caught at compare match
  reg unread; // captured value not read yet
  wire [1:0] input_select = ctl[`TCC_F_SEL_HI:`TCC_F_SEL_LO];
  wire [1:0] capture_edge_sel = ctl[`TCC_F_EDGE_HI:`TCC_F_EDGE_LO];
  wire capture_mode_sel = ctl[`TCC_F_CAPM];
  wire sync_capture = ctl[`TCC_F_SYNC];
  wire [2:0] out_mode = ctl[`TCC_F_MODE_HI:`TCC_F_MODE_LO];
  // high select bit picks a fixed level, low bit gives it
  wire input_level = input_select[1] ? input_select[0] :
    (input_select[0] ? capture_in_b : capture_in_a);
  wire rise = input_level & ~lvl_prev;
  wire fall = ~input_level & lvl_prev;
  // edge code bit 0 rising, bit 1 falling, both for 11
  wire edge_hit = (capture_edge_sel[0] & rise) | (capture_edge_sel[1] & fall);
  // synchronised capture waits one clock edge
  wire cap_now = capture_mode_sel & (sync_capture ? cap_pend : edge_hit);
  // equality on every count step, either direction
  assign chan_match = count_tick & (count_value == chan_value_reg);
  wire cmp_hit = chan_match & ~capture_mode_sel;
  assign chan_irq_enable = ctl[`TCC_F_IE];
  // read view, input level live
  assign ctl_rd = {ctl[15:11], latched_input, 1'b0, ctl[8:4], input_level,
    ctl[2], capture_overrun, chan_irq_flag};
  ///////////////////////////////////////////////////////////////////////
  // capture, flags and control
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctl <= `TCC_CTL_RST;
      chan_value_reg <= `TCC_VAL_RST;
      chan_irq_flag <= 1'b0;
      capture_overrun <= 1'b0;
      lvl_prev <= 1'b0;
      cap_pend <= 1'b0;
      latched_input <= 1'b0;
      unread <= 1'b0;
    end else begin
      lvl_prev <= input_level;
      cap_pend <= capture_mode_sel & sync_capture & edge_hit;
      if (ctl_wr) begin
        ctl <= wr_data & `TCC_CTL_WMASK;
      end
      // counter copied on capture, capture beats a write
      if (cap_now) begin
        chan_value_reg <= count_value;
      end else if (val_wr) begin
        chan_value_reg <= wr_data;
      end
      // hardware set wins over software or vector clear
      if (cap_now | cmp_hit) begin
        chan_irq_flag <= 1'b1;
      end else if (ctl_wr) begin
        chan_irq_flag <= wr_data[`TCC_F_FLAG];
      end else if (flag_clr) begin
        chan_irq_flag <= 1'b0;
      end
      // overrun set by hardware, cleared only by writing 0
      if (cap_now & unread) begin
        capture_overrun <= 1'b1;
      end else if (ctl_wr & ~wr_data[`TCC_F_OVR]) begin
        capture_overrun <= 1'b0;
      end
      // value pending read, set wins
      if (cap_now) begin
        unread <= 1'b1;
      end else if (val_rd_done) begin
        unread <= 1'b0;
      end
      if (chan_match) begin
        latched_input <= input_level;
      end
    end
  end
  ///////////////////////////////////////////////////////////////////////
  // output unit, clocked in every mode
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      chan_out <= 1'b0;
    end else begin
      case (out_mode)
        `TCC_MODE_OUT: chan_out <= ctl[`TCC_F_OUTV];
        `TCC_MODE_SET: if (chan_match) chan_out <= 1'b1;
        `TCC_MODE_RST: if (chan_match) chan_out <= 1'b0;
        `TCC_MODE_TGL: if (chan_match) chan_out <= ~chan_out;
        `TCC_MODE_TGL_RST: begin
          if (chan0_match) chan_out <= 1'b0;
          else if (chan_match) chan_out <= ~chan_out;
        end
        `TCC_MODE_TGL_SET: begin
          if (chan0_match) chan_out <= 1'b1;
          else if (chan_match) chan_out <= ~chan_out;
        end
        `TCC_MODE_SET_RST: begin
          if (chan0_match) chan_out <= 1'b0;
          else if (chan_match) chan_out <= 1'b1;
        end
        `TCC_MODE_RST_SET: begin
          if (chan0_match) chan_out <= 1'b1;
          else if (chan_match) chan_out <= 1'b0;
        end
        default: chan_out <= chan_out;
      endcase
    end
  end
endmodule // tcc_chan

// ### core/tcc_top.v
// three capture/compare channels, interrupt flags and vector logic
// assumes the counter supplies count_value and a one-cycle count_tick
// whenever it moves, and an overflow_event pulse, all on clk_sys
// the avalon master holds its request until waitrequest is low
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`include "tcc_regs.vh"

// Behaviour
// - capture mode bit selects capture behaviour
// - select input a/b, edge rising/falling/both
// - capture copies counter, sets channel flag
// - live input level readable any time
// - sync bit delays capture one clock
// - second unread capture sets overrun bit
// - high select bit feeds fixed level
// - compare equality sets flag, drives output
// - match latches input level
// - output clocked; mode 0 follows bit
// - modes 1, 5 set or reset
// - modes 2, 6 toggle with chan0 reset/set
// - modes 3, 7 set/reset with chan0
// - mode 4 toggles on every match
// - matches counted in both directions
// - chan0 vector and shared vector
// - flags software writable, gated by enables
// - chan0 flag cleared when serviced
// - vector shows top enabled pending source
// - vector access clears top pending flag
// - vector codes 0, 2, 4, 10
module tcc_top (
  input wire clk_sys,
  input wire rst_b,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [15:0] count_value,
  input wire count_tick,
  input wire overflow_event,
  input wire [2:0] capture_in_a,
  input wire [2:0] capture_in_b,
  input wire global_irq_enable,
  input wire chan0_irq_ack,
  output wire [2:0] chan_out,
  output reg irq_chan0,
  output reg irq_shared
);

  ///////////////////////////////////////////////////////////////////////
  // decode helpers

  // true when the word index addresses a control register
  function is_ctl;
    input [3:0] idx;
    begin
      is_ctl = (idx == `TCC_IDX_CTL0) | (idx == `TCC_IDX_CTL1) |
        (idx == `TCC_IDX_CTL2);
    end
  endfunction

  // true when the word index addresses a value register
  function is_val;
    input [3:0] idx;
    begin
      is_val = (idx == `TCC_IDX_VAL0) | (idx == `TCC_IDX_VAL1) |
        (idx == `TCC_IDX_VAL2);
    end
  endfunction

  // channel number carried in the low two index bits
  function [1:0] chan_of;
    input [3:0] idx;
    begin
      chan_of = idx[1:0];
    end
  endfunction

  ///////////////////////////////////////////////////////////////////////
  // bus handshake

  // waitrequest low for exactly one cycle per request
  wire req = avs_read | avs_write;
  // access completes at this edge
  wire done = req & ~avs_waitrequest;
  // first cycle of a request, read data are prepared here
  wire first = req & avs_waitrequest;
  // completed write and read strobes
  wire wr_done = done & avs_write;
  wire rd_done = done & avs_read;

  // register answer one cycle after the request is seen
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_waitrequest <= 1'b1;
    end else if (first) begin
      // release the master at the next edge
      avs_waitrequest <= 1'b0;
    end else begin
      // idle or just completed: hold off
      avs_waitrequest <= 1'b1;
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // channel instances

  wire [47:0] ctl_all; // control read views, 16 bits each
  wire [47:0] val_all; // value registers, 16 bits each
  wire [2:0] flag_all; // channel flags
  wire [2:0] ie_all; // channel enables
  wire [2:0] match_all; // equality pulses
  wire [2:0] flag_clr; // per-channel clear from vector or service
  reg overflow_flag; // counter overflow flag
  reg overflow_irq_enable; // enable for the overflow flag
  reg [3:0] vec_hold; // vector taken at the first cycle of an access

  // channel 0 is cleared when its request is serviced
  assign flag_clr[0] = chan0_irq_ack;
  // vector access clears the source the vector named
  assign flag_clr[1] = done & (avs_address == `TCC_IDX_VEC) &
    (vec_hold == `TCC_VEC_CH1);
  assign flag_clr[2] = done & (avs_address == `TCC_IDX_VEC) &
    (vec_hold == `TCC_VEC_CH2);

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_chan
      // per-channel decode of completed writes and reads
      wire ctl_hit = is_ctl(avs_address) & (chan_of(avs_address) == gi);
      wire val_hit = is_val(avs_address) & (chan_of(avs_address) == gi);
      tcc_chan u_chan (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ctl_wr(wr_done & ctl_hit),
        .val_wr(wr_done & val_hit),
        .wr_data(avs_writedata[15:0]),
        .val_rd_done(rd_done & val_hit),
        .flag_clr(flag_clr[gi]),
        .count_value(count_value),
        .count_tick(count_tick),
        .chan0_match(match_all[0]),
        .capture_in_a(capture_in_a[gi]),
        .capture_in_b(capture_in_b[gi]),
        .ctl_rd(ctl_all[gi*16+15:gi*16]),
        .chan_value_reg(val_all[gi*16+15:gi*16]),
        .chan_irq_flag(flag_all[gi]),
        .chan_irq_enable(ie_all[gi]),
        .chan_match(match_all[gi]),
        .chan_out(chan_out[gi])
      );
    end
  endgenerate

  ///////////////////////////////////////////////////////////////////////
  // interrupt vector generator

  // pending and enabled sources on the shared vector
  wire pend1 = flag_all[1] & ie_all[1];
  wire pend2 = flag_all[2] & ie_all[2];
  wire pend_ovf = overflow_flag & overflow_irq_enable;

  // highest enabled source wins, disabled ones are ignored
  reg [3:0] irq_vector_reg;
  always @* begin
    if (pend1) begin
      irq_vector_reg = `TCC_VEC_CH1;
    end else if (pend2) begin
      irq_vector_reg = `TCC_VEC_CH2;
    end else if (pend_ovf) begin
      irq_vector_reg = `TCC_VEC_OVF;
    end else begin
      irq_vector_reg = `TCC_VEC_NONE;
    end
  end

  // vector captured with the read data so the clear matches it
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vec_hold <= `TCC_VEC_NONE;
    end else if (first) begin
      vec_hold <= irq_vector_reg;
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // overflow flag and its enable

  // overflow flag: event wins over any clear
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      overflow_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
    end else begin
      if (overflow_event) begin
        // counter wrapped
        overflow_flag <= 1'b1;
      end else if (wr_done & (avs_address == `TCC_IDX_OVF)) begin
        // software sets or clears the flag
        overflow_flag <= avs_writedata[`TCC_F_OVF_FLAG];
      end else if (done & (avs_address == `TCC_IDX_VEC) &
          (vec_hold == `TCC_VEC_OVF)) begin
        // vector access clears the named source
        overflow_flag <= 1'b0;
      end
      if (wr_done & (avs_address == `TCC_IDX_OVF)) begin
        overflow_irq_enable <= avs_writedata[`TCC_F_OVF_IE];
      end
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // interrupt requests

  // dedicated and shared requests, each gated by global enable
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq_chan0 <= 1'b0;
      irq_shared <= 1'b0;
    end else begin
      // channel 0 alone, highest priority
      irq_chan0 <= global_irq_enable & flag_all[0] & ie_all[0];
      // any remaining pending source raises a new request
      irq_shared <= global_irq_enable & (pend1 | pend2 | pend_ovf);
    end
  end

  ///////////////////////////////////////////////////////////////////////
  // read data

  // read mux, unmapped words read as zero
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    if (is_ctl(avs_address)) begin
      // control view of the addressed channel
      case (chan_of(avs_address))
        2'h0: rd_mux = ctl_all[15:0];
        2'h1: rd_mux = ctl_all[31:16];
        2'h2: rd_mux = ctl_all[47:32];
        default: rd_mux = 16'h0000;
      endcase
    end else if (is_val(avs_address)) begin
      // capture/compare value of the addressed channel
      case (chan_of(avs_address))
        2'h0: rd_mux = val_all[15:0];
        2'h1: rd_mux = val_all[31:16];
        2'h2: rd_mux = val_all[47:32];
        default: rd_mux = 16'h0000;
      endcase
    end else if (avs_address == `TCC_IDX_VEC) begin
      // vector number in the low bits
      rd_mux = {12'h000, irq_vector_reg};
    end else if (avs_address == `TCC_IDX_OVF) begin
      // overflow flag and enable
      rd_mux = {14'h0000, overflow_irq_enable, overflow_flag};
    end
  end

  // read data registered on the first cycle, stand at completion
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h00000000;
    end else if (first & avs_read) begin
      // upper half always zero
      avs_readdata <= {16'h0000, rd_mux};
    end
  end

endmodule // tcc_top

// ### sim/tcc_assertions.sv
// checker for bus timing, irq gating, vector codes, output causes
// assumes a bind to tcc_top, one clock domain
`timescale 1ns/100ps
module tcc_assertions (
  input wire clk_sys,
  input wire rst_b,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire count_tick,
  input wire global_irq_enable,
  input wire [2:0] chan_out,
  input wire irq_chan0,
  input wire irq_shared
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire rd_done = avs_read && !avs_waitrequest; // read completes at this edge
  ////////////////////////////////////////
  wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer one cycle after request");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  wait_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("answer without request");
  vec_codes_a: assert property (rd_done && avs_address == 4'h8 |-> avs_readdata == 32'h0 ||
    avs_readdata == 32'h2 || avs_readdata == 32'h4 || avs_readdata == 32'ha)
    else $error("vector read outside its codes");
  ctl_zero_a: assert property (rd_done && avs_address < 4'h3 |->
    avs_readdata[31:16] == 16'h0000 && !avs_readdata[9]) else $error("control read spare bits");
  gate_ch0_a: assert property (!global_irq_enable |=> !irq_chan0)
    else $error("channel 0 irq without global enable");
  gate_shared_a: assert property (!global_irq_enable |=> !irq_shared)
    else $error("shared irq without global enable");
  out_cause_a: assert property (!$stable(chan_out) |->
    $past(count_tick) || $past(avs_write && !avs_waitrequest, 2)) else $error("output moved uncaused");
  // main scenarios reached
  cov_vec: cover property (rd_done && avs_address == 4'h8 && avs_readdata != 32'h0);
  cov_out: cover property ($rose(chan_out[1]));
  cov_irq: cover property ($rose(irq_chan0));
endmodule // tcc_assertions

// ### sim/tcc_count_model.sv
// stand-in for the timer counter: up to top, or up and down
// assumes run, updown and top driven on clk_sys by the bench
`timescale 1ns/100ps
module tcc_count_model (
  input wire clk_sys,
  input wire rst_b,
  input wire run,
  input wire updown,
  input wire [15:0] top,
  output reg [15:0] count_value,
  output reg count_tick,
  output reg overflow_event
);
  reg down; // direction while counting up and down
  // tick marks every cycle in which the count moved
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_value <= 16'h0000;
      count_tick <= 1'b0;
      overflow_event <= 1'b0;
      down <= 1'b0;
    end else begin
      count_tick <= run;
      overflow_event <= 1'b0;
      if (run && !updown) begin // wrap to zero after top
        count_value <= (count_value == top) ? 16'h0000 : count_value + 16'h0001;
        overflow_event <= (count_value == top);
      end else if (run) begin // turn at top and at zero
        if (count_value == top) down <= 1'b1;
        else if (count_value == 16'h0000) down <= 1'b0;
        if (count_value == top || (down && count_value != 16'h0000)) count_value <= count_value - 16'h0001;
        else count_value <= count_value + 16'h0001;
        overflow_event <= down && count_value == 16'h0001;
      end
    end
  end
endmodule // tcc_count_model

// ### sim/tb_top.sv
// bench: registers over avalon, captures, output modes, interrupts
// assumes tcc_top, tcc_count_model and the checker on the search path
`timescale 1ns/100ps
module tb_top;
  reg clk_sys = 1'b0;
  reg rst_b = 1'b0;
  reg [3:0] avs_address = 4'h0;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [15:0] count_value;
  wire count_tick;
  wire overflow_event;
  reg [2:0] capture_in_a = 3'h0;
  reg [2:0] capture_in_b = 3'h0;
  reg global_irq_enable = 1'b0;
  reg chan0_irq_ack = 1'b0;
  wire [2:0] chan_out;
  wire irq_chan0;
  wire irq_shared;
  reg run = 1'b0; // counter moving
  reg updown = 1'b0;
  reg [15:0] top = 16'h0013;
  reg [2:0] mode_q = 3'h0; // mirror of channel 1 mode and value bit
  reg out_q = 1'b0;
  reg [15:0] v0_q = 16'h0000; // mirrors of compare values
  reg [15:0] v1_q = 16'h0000;
  reg exp_out = 1'b0; // expected channel 1 output
  reg [31:0] q;
  reg [15:0] cap_v;
  reg [15:0] old_v;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer i;
  integer seed_init;
  always #20 clk_sys = ~clk_sys;
  tcc_top i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .count_value(count_value),
    .count_tick(count_tick), .overflow_event(overflow_event), .capture_in_a(capture_in_a),
    .capture_in_b(capture_in_b), .global_irq_enable(global_irq_enable),
    .chan0_irq_ack(chan0_irq_ack), .chan_out(chan_out), .irq_chan0(irq_chan0),
    .irq_shared(irq_shared));
  tcc_count_model i_cnt (.clk_sys(clk_sys), .rst_b(rst_b), .run(run), .updown(updown),
    .top(top), .count_value(count_value), .count_tick(count_tick),
    .overflow_event(overflow_event));
  ////////////////////////////////////////
  // next output of one unit from mode, old output and matches
  function logic nxt(input [2:0] m, input logic o, input logic e1, input logic e0);
    case (m)
      3'h1: nxt = e1 ? 1'b1 : o;
      3'h2: nxt = e0 ? 1'b0 : (e1 ? ~o : o);
      3'h3: nxt = e0 ? 1'b0 : (e1 ? 1'b1 : o);
      3'h4: nxt = e1 ? ~o : o;
      3'h5: nxt = e1 ? 1'b0 : o;
      3'h6: nxt = e0 ? 1'b1 : (e1 ? ~o : o);
      default: nxt = e0 ? 1'b1 : (e1 ? 1'b0 : o);
    endcase
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("unexpected %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task acc(input logic w, input logic [3:0] a, input logic [15:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= w;
      avs_read <= !w;
      n = 0;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && n < 20) begin
        @(posedge clk_sys);
        n = n + 1;
      end
      if (n >= 20) n_errors = n_errors + 1;
      if (n >= 20) stop_test;
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (w && a == 4'h1) {mode_q, out_q} <= {d[7:5], d[2]};
      if (w && a == 4'h4) v0_q <= d;
      if (w && a == 4'h5) v1_q <= d;
    end
  endtask
  // let the counter move, then note where it stopped
  task spin(input integer n);
    begin
      run <= 1'b1;
      repeat (n) @(posedge clk_sys);
      run <= 1'b0;
      repeat (2) @(posedge clk_sys);
      cap_v = count_value;
    end
  endtask
  ////////////////////////////////////////
  // reference output, compared every cycle
  always @(posedge clk_sys) begin
    if (mode_q == 3'h0) exp_out <= out_q;
    else if (count_tick) exp_out <= nxt(mode_q, exp_out, count_value == v1_q, count_value == v0_q);
  end
  always @(negedge clk_sys) begin
    if (rst_b) chk("chan_out1", {31'h0, exp_out}, {31'h0, chan_out[1]});
  end
  initial begin
    seed_init = $urandom(42);
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (i = 0; i < 16; i = i + 1) begin
      acc(1'b0, i[3:0], 16'h0000);
      chk("reset_word", 32'h0, q);
    end
    $display("test reset done");
    spin($urandom_range(30, 5));
    acc(1'b1, 4'h1, 16'hf900); // fixed high level, both edges
    acc(1'b1, 4'h1, 16'he900); // second capture unread
    repeat (4) @(posedge clk_sys);
    acc(1'b0, 4'h1, 16'h0);
    chk("ovr_flag", 32'h3, q & 32'hb);
    acc(1'b0, 4'h5, 16'h0);
    chk("cap_val", {16'h0, cap_v}, q);
    acc(1'b1, 4'h1, 16'hf902); // overrun bit written 1 keeps it
    repeat (4) @(posedge clk_sys);
    acc(1'b0, 4'h1, 16'h0);
    chk("ovr_kept", 32'hb, q & 32'hb);
    acc(1'b1, 4'h1, 16'hf900);
    acc(1'b0, 4'h1, 16'h0);
    chk("ovr_clear", 32'hf908, q);
    acc(1'b1, 4'h2, 16'h4100); // rising edges of input a
    capture_in_a <= 3'h4;
    repeat (4) @(posedge clk_sys);
    old_v = cap_v;
    spin($urandom_range(9, 3));
    capture_in_a <= 3'h0; // falling edge ignored
    repeat (4) @(posedge clk_sys);
    acc(1'b0, 4'h6, 16'h0);
    chk("cap_rise", {16'h0, old_v}, q);
    acc(1'b1, 4'h2, 16'hd100); // input b, both edges
    capture_in_b <= 3'h4;
    repeat (4) @(posedge clk_sys);
    acc(1'b0, 4'h6, 16'h0);
    chk("cap_b", {16'h0, cap_v}, q);
    $display("test capture done");
    capture_in_a <= 3'h2;
    acc(1'b1, 4'h4, 16'h0013);
    acc(1'b1, 4'h5, 16'h0007);
    for (i = 0; i < 8; i = i + 1) begin
      acc(1'b1, 4'h1, 16'h00e0); // pass through mode 7
      acc(1'b1, 4'h1, {8'h00, i[2:0], 5'h00} | (16'h0004 & $urandom));
      spin(45);
    end
    acc(1'b0, 4'h1, 16'h0);
    chk("match_bits", 32'h0409, q & 32'h0409);
    updown <= 1'b1;
    acc(1'b1, 4'h1, 16'h0080);
    spin(60);
    updown <= 1'b0;
    $display("test compare done");
    global_irq_enable <= 1'b1;
    acc(1'b1, 4'h1, 16'h0011);
    acc(1'b1, 4'h2, 16'h0011);
    acc(1'b1, 4'h9, 16'h0003);
    repeat (2) @(posedge clk_sys);
    chk("irq_shared", 32'h1, {31'h0, irq_shared});
    acc(1'b0, 4'h8, 16'h0);
    chk("vec_ch1", 32'h2, q);
    acc(1'b0, 4'h8, 16'h0);
    chk("vec_ch2", 32'h4, q);
    acc(1'b1, 4'h8, 16'h0);
    acc(1'b0, 4'h8, 16'h0);
    chk("vec_none", 32'h0, q);
    acc(1'b1, 4'h1, 16'h0001); // pending, not enabled
    acc(1'b1, 4'h9, 16'h0003);
    acc(1'b0, 4'h8, 16'h0);
    chk("vec_ovf", 32'ha, q);
    acc(1'b0, 4'h1, 16'h0);
    chk("masked_kept", 32'h1, q & 32'h1);
    acc(1'b1, 4'h0, 16'h0011);
    repeat (2) @(posedge clk_sys);
    chk("irq_ch0", 32'h1, {31'h0, irq_chan0});
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("irq_ch0_gated", 32'h0, {31'h0, irq_chan0});
    global_irq_enable <= 1'b1;
    chan0_irq_ack <= 1'b1;
    @(posedge clk_sys);
    chan0_irq_ack <= 1'b0;
    repeat (2) @(posedge clk_sys);
    acc(1'b0, 4'h0, 16'h0);
    chk("ack_clear", 32'h0, {31'h0, irq_chan0 | q[0]});
    $display("test interrupt done");
    stop_test;
  end
endmodule // tb_top
bind tcc_top tcc_assertions i_chk (.clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .count_tick(count_tick),
  .global_irq_enable(global_irq_enable), .chan_out(chan_out), .irq_chan0(irq_chan0),
  .irq_shared(irq_shared));
